/* rtl/watch_timer_cfg.svh */
// Constants for the sub-clock watch timer: register location, field
// positions, reset values and counter tap points.
// Assumes inclusion by bare name from the design files of this block.
`ifndef WATCH_TIMER_CFG_SVH
`define WATCH_TIMER_CFG_SVH

// Register index as printed; byte address is four times the index
`define WTCTL_INDEX 12'h0aa
`define WTCTL_ADDR 12'h2a8

// Control register field positions
`define FLD_WD_CLK_SEL 7
`define FLD_OSC_SETTLED 6
`define FLD_IRQ_ENABLE 5
`define FLD_INTERVAL_FLAG 4
`define FLD_COUNTER_CLEAR 3
`define FLD_INTERVAL_SEL_HI 2
`define FLD_INTERVAL_SEL_LO 0

// Reset values
`define RST_WD_CLK_SEL 1'b1
`define RST_IRQ_ENABLE 1'b0
`define RST_INTERVAL_FLAG 1'b0
`define RST_INTERVAL_SEL 3'h0
`define RST_PRDATA 32'h0000_0000

// Counter geometry and taps, in sub-clock periods as powers of two
`define COUNT_WIDTH 15
`define COUNT_ZERO 15'h0000
`define INTERVAL_BASE_BITS 5'h09
`define INTERVAL_SEL_DISABLED 3'h7
`define OSC_WAIT_BITS 5'h0e
`define WD_TAP_BITS 5'h0a

`endif

/* rtl/watch_timer_pkg.sv */
// Types shared by the sub-clock watch timer files.
// Assumes watch_timer_cfg.svh supplies the numeric constants.
package watch_timer_pkg;

  typedef enum logic [1:0] {
    OSC_HOLD,
    OSC_WAIT,
    OSC_SETTLED
  } osc_state_t;

  typedef logic [14:0] watch_count_t;

endpackage

/* rtl/watch_counter.sv */
// Sub-clock synchroniser and 15-bit watch counter.
// Assumes sclk_pin is asynchronous to clk and far slower than clk.
`timescale 1ns/1ps
`include "watch_timer_cfg.svh"

module watch_counter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk_pin,
  input wire logic clear,
  output watch_timer_pkg::watch_count_t count,
  output logic step
);

  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_meta <= sclk_pin;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  // One enable per sub-clock rising edge; stops when the sub-clock stops
  assign step = sclk_sync & ~sclk_prev;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= `COUNT_ZERO;
    end else if (clear) begin
      count <= `COUNT_ZERO;
    end else if (step) begin
      count <= count + 15'h0001;
    end
  end

endmodule

/* rtl/subclock_watch_timer.sv */
// Sub-clock watch timer: interval flag and interrupt, sub-clock
// oscillation wait timing, watchdog clock selection, APB control register.
// Assumes an APB master on clk; stop_mode, subclock_mode, sub_watch_mode and
// timebase_tick come from logic on clk; sclk_pin, hw_standby_n_pin and
// ext_reset_n_pin are asynchronous pins.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "watch_timer_cfg.svh"

module subclock_watch_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_pin,
  input wire logic stop_mode,
  input wire logic hw_standby_n_pin,
  input wire logic subclock_mode,
  input wire logic sub_watch_mode,
  input wire logic ext_reset_n_pin,
  input wire logic timebase_tick,
  output logic irq,
  output logic wd_clk_tick,
  output logic osc_settled,
  output logic ext_reset_req
);

  // True when the step about to happen carries out of the low nbits bits
  function automatic logic carry_out(input watch_timer_pkg::watch_count_t cnt, input logic [4:0] nbits);
    logic [15:0] nxt;
    logic [15:0] mask;
    nxt = {1'b0, cnt} + 16'h0001;
    mask = (16'h0001 << nbits) - 16'h0001;
    carry_out = (nbits != 5'h00) && ((nxt & mask) == 16'h0000);
  endfunction

  // Control register state
  logic wd_clk_sel;
  logic irq_enable;
  logic interval_flag;
  logic [2:0] interval_sel;
  watch_timer_pkg::osc_state_t osc_state;
  watch_timer_pkg::osc_state_t next_osc_state;

  // Pin synchronisers
  logic standby_meta;
  logic standby_sync_n;
  logic ext_reset_meta;
  logic ext_reset_sync_n;

  // Mode edge tracking
  logic stop_prev;
  logic standby_prev;

  // Counter interface
  watch_timer_pkg::watch_count_t count;
  logic step;
  logic counter_clear;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      standby_meta <= 1'b1;
      standby_sync_n <= 1'b1;
      ext_reset_meta <= 1'b1;
      ext_reset_sync_n <= 1'b1;
    end else begin
      standby_meta <= hw_standby_n_pin;
      standby_sync_n <= standby_meta;
      ext_reset_meta <= ext_reset_n_pin;
      ext_reset_sync_n <= ext_reset_meta;
    end
  end

  wire in_standby = ~standby_sync_n;
  wire in_low_power = stop_mode | in_standby;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stop_prev <= 1'b0;
      standby_prev <= 1'b0;
    end else begin
      stop_prev <= stop_mode;
      standby_prev <= in_standby;
    end
  end

  wire stop_entry = stop_mode & ~stop_prev;
  wire standby_entry = in_standby & ~standby_prev;
  wire mode_entry = stop_entry | standby_entry;
  wire low_power_exit = (stop_prev | standby_prev) & ~in_low_power;

  // APB decode: zero wait states, answer prepared in the setup cycle
  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready;
  wire addr_hit = (paddr == `WTCTL_ADDR);
  wire reg_write = access_done & pwrite & addr_hit & pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];

  wire sw_flag_clear = reg_write & ~wbyte[`FLD_INTERVAL_FLAG];
  wire sw_counter_clear = reg_write & ~wbyte[`FLD_COUNTER_CLEAR];

  // Software clear is held off during the oscillation wait so it stays fixed
  wire wait_active = (osc_state != watch_timer_pkg::OSC_SETTLED);
  assign counter_clear = in_low_power | (sw_counter_clear & ~wait_active);

  watch_counter u_counter (
    .clk(clk),
    .resetn(resetn),
    .sclk_pin(sclk_pin),
    .clear(counter_clear),
    .count(count),
    .step(step)
  );

  wire live_step = step & ~counter_clear;

  // Interval taps: select 0 is 2^9 periods up to select 6 at 2^15
  wire [4:0] interval_bits = `INTERVAL_BASE_BITS + {2'b00, interval_sel};
  wire interval_valid = (interval_sel != `INTERVAL_SEL_DISABLED);
  wire interval_hit = live_step & interval_valid & carry_out(count, interval_bits);
  wire osc_wait_hit = live_step & carry_out(count, `OSC_WAIT_BITS);
  wire watch_out_tick = live_step & carry_out(count, `WD_TAP_BITS);

  // Flag: entry to a low-power mode wins, then a hit beats a software clear
  wire next_flag = mode_entry ? 1'b0 :
                   interval_hit ? 1'b1 :
                   sw_flag_clear ? 1'b0 :
                   interval_flag;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      interval_flag <= `RST_INTERVAL_FLAG;
    end else begin
      interval_flag <= next_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wd_clk_sel <= `RST_WD_CLK_SEL;
      irq_enable <= `RST_IRQ_ENABLE;
      interval_sel <= `RST_INTERVAL_SEL;
    end else if (reg_write) begin
      wd_clk_sel <= wbyte[`FLD_WD_CLK_SEL];
      irq_enable <= wbyte[`FLD_IRQ_ENABLE];
      interval_sel <= wbyte[`FLD_INTERVAL_SEL_HI:`FLD_INTERVAL_SEL_LO];
    end
  end

  // Oscillation wait: held while in stop or standby, timed after leaving
  always_comb begin
    next_osc_state = osc_state;
    case (osc_state)
      watch_timer_pkg::OSC_HOLD: begin
        if (low_power_exit) begin
          next_osc_state = watch_timer_pkg::OSC_WAIT;
        end
      end
      watch_timer_pkg::OSC_WAIT: begin
        if (in_low_power) begin
          next_osc_state = watch_timer_pkg::OSC_HOLD;
        end else if (osc_wait_hit) begin
          next_osc_state = watch_timer_pkg::OSC_SETTLED;
        end
      end
      watch_timer_pkg::OSC_SETTLED: begin
        if (in_low_power) begin
          next_osc_state = watch_timer_pkg::OSC_HOLD;
        end
      end
      default: begin
        next_osc_state = watch_timer_pkg::OSC_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      osc_state <= watch_timer_pkg::OSC_WAIT;
    end else begin
      osc_state <= next_osc_state;
    end
  end

  // Watchdog clock: the two sources are unrelated, so glitches on a
  // select change are the software's to handle by clearing the watchdog
  wire wd_source = subclock_mode ? (wd_clk_sel ? 1'b0 : watch_out_tick) :
                   (wd_clk_sel ? timebase_tick : watch_out_tick);

  // Register read image; clear bit always reads zero
  wire [7:0] read_image = {wd_clk_sel,
                           (osc_state == watch_timer_pkg::OSC_SETTLED),
                           irq_enable,
                           interval_flag,
                           1'b0,
                           interval_sel};

  wire [31:0] next_prdata = (setup_phase & ~pwrite & addr_hit) ? {24'h000000, read_image} : `RST_PRDATA;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= `RST_PRDATA;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= next_prdata;
      pready <= 1'b1;
      pslverr <= ~addr_hit;
    end else begin
      prdata <= `RST_PRDATA;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Output stage: plain CPU request level, no transfer-service handshake
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
      wd_clk_tick <= 1'b0;
      osc_settled <= 1'b0;
      ext_reset_req <= 1'b0;
    end else begin
      irq <= interval_flag & irq_enable;
      wd_clk_tick <= wd_source;
      osc_settled <= (osc_state == watch_timer_pkg::OSC_SETTLED);
      ext_reset_req <= ~ext_reset_sync_n & ~sub_watch_mode;
    end
  end

endmodule

/* bench/subclock_watch_timer_chk.sv */
// Port checker for the sub-clock watch timer.
// Assumes APB requests stay held until pready, and binds to the top module.
`timescale 1ns/1ps
`include "watch_timer_cfg.svh"
module subclock_watch_timer_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_mode,
  input wire logic sub_watch_mode,
  input wire logic irq,
  input wire logic osc_settled,
  input wire logic ext_reset_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wire wr_hit = psel && penable && pready && pwrite && pstrb[0] && paddr == `WTCTL_ADDR;

  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_answer_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (pready && paddr != `WTCTL_ADDR |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_read_fields: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0 && !prdata[3])
    else $error("unused or clear bits read nonzero");
  a_enable_off: assert property (wr_hit && !pwdata[5] |=> ##1 !irq)
    else $error("irq with enable off");
  a_flag_write: assert property (wr_hit && !pwdata[4] |=> ##1 !irq)
    else $error("irq kept after flag clear");
  a_stop_quiet: assert property ($rose(stop_mode) |-> ##[1:4] (!irq && !osc_settled))
    else $error("stop entry left flag or status");
  a_stop_held: assert property (stop_mode [*8] |-> !irq)
    else $error("irq during stop");
  a_no_ext_exit: assert property (sub_watch_mode [*2] |-> !ext_reset_req)
    else $error("external reset in sub watch mode");
endmodule

bind subclock_watch_timer subclock_watch_timer_chk i_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .stop_mode, .sub_watch_mode, .irq, .osc_settled, .ext_reset_req);

/* bench/wd_partner.sv */
// Watchdog stand-in: counts the count-clock pulses it is given.
// Assumes wd_clk_tick is a one-cycle pulse on clk.
`timescale 1ns/1ps
module wd_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wd_clk_tick,
  output logic [15:0] wd_ticks
);
  // Counts only; a stopped clock simply leaves the count still
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wd_ticks <= 16'h0000;
    end else if (wd_clk_tick) begin
      wd_ticks <= wd_ticks + 16'h0001;
    end
  end
endmodule

/* bench/subclock_watch_timer_tb.sv */
// Self-checking bench for the sub-clock watch timer over APB.
// Assumes the checker binds itself; sub-clock edges are 8 clk apart.
`timescale 1ns/1ps
`include "watch_timer_cfg.svh"
module subclock_watch_timer_tb;
  localparam logic [11:0] reg_addr = `WTCTL_ADDR;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sclk_pin = 1'b0;
  logic stop_mode = 1'b0, hw_standby_n_pin = 1'b1, subclock_mode = 1'b0, sub_watch_mode = 1'b0;
  logic ext_reset_n_pin = 1'b1, timebase_tick = 1'b0, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, irq, wd_clk_tick, osc_settled, ext_reset_req;
  logic [15:0] wd_ticks, t0;
  int bad_count = 0, total_checks = 0;

  subclock_watch_timer i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_pin(sclk_pin), .stop_mode(stop_mode), .hw_standby_n_pin(hw_standby_n_pin),
    .subclock_mode(subclock_mode), .sub_watch_mode(sub_watch_mode), .ext_reset_n_pin(ext_reset_n_pin),
    .timebase_tick(timebase_tick), .irq(irq), .wd_clk_tick(wd_clk_tick), .osc_settled(osc_settled),
    .ext_reset_req(ext_reset_req));
  wd_partner i_wd (.clk(clk), .resetn(resetn), .wd_clk_tick(wd_clk_tick), .wd_ticks(wd_ticks));

  always #10 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // Answer is read at the falling edge so it never races the slave's update
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(negedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(negedge clk);
      n++;
    end
    if (n == 16) begin
      bad_count++;
      summarize();
    end
    rdata = prdata;
    rerr = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sub_edges(input int n);
    repeat (n) begin
      @(posedge clk);
      sclk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, reg_addr, 8'h00);
    chk(rdata, 32'h80);
    apb(1'b0, 12'h2ac, 8'h00);
    chk_bit(rerr, 1'b1);
    chk(rdata, 32'h0);
    apb(1'b1, reg_addr, 8'h38);
    pstrb <= 4'h0;
    apb(1'b1, reg_addr, 8'h00);
    pstrb <= 4'hf;
    apb(1'b0, reg_addr, 8'h00);
    chk(rdata, 32'h20);
    sub_edges(511);
    settle(12);
    chk_bit(irq, 1'b0);
    sub_edges(1);
    settle(12);
    chk_bit(irq, 1'b1);
    apb(1'b0, reg_addr, 8'h00);
    chk(rdata, 32'h30);
    apb(1'b1, reg_addr, 8'h28);
    settle(2);
    chk_bit(irq, 1'b0);
    apb(1'b1, reg_addr, 8'h08);
    sub_edges(512);
    settle(12);
    chk_bit(irq, 1'b0);
    apb(1'b0, reg_addr, 8'h00);
    chk(rdata, 32'h10);
    apb(1'b1, reg_addr, 8'h38);
    settle(2);
    chk_bit(irq, 1'b1);
    t0 = wd_ticks;
    sub_edges(1024);
    chk({16'h0, wd_ticks - t0}, 32'h1);
    apb(1'b1, reg_addr, 8'ha8);
    t0 = wd_ticks;
    timebase_tick <= 1'b1;
    @(posedge clk);
    timebase_tick <= 1'b0;
    settle(3);
    chk({16'h0, wd_ticks - t0}, 32'h1);
    @(posedge clk);
    subclock_mode <= 1'b1;
    t0 = wd_ticks;
    timebase_tick <= 1'b1;
    @(posedge clk);
    timebase_tick <= 1'b0;
    sub_edges(1024);
    chk({16'h0, wd_ticks - t0}, 32'h0);
    apb(1'b1, reg_addr, 8'h28);
    t0 = wd_ticks;
    sub_edges(1024);
    chk({16'h0, wd_ticks - t0}, 32'h1);
    @(posedge clk);
    subclock_mode <= 1'b0;
    stop_mode <= 1'b1;
    settle(4);
    chk_bit(irq, 1'b0);
    sub_edges(600);
    settle(12);
    chk_bit(irq, 1'b0);
    chk_bit(osc_settled, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b0;
    sub_edges(511);
    settle(12);
    chk_bit(irq, 1'b0);
    sub_edges(1);
    settle(12);
    chk_bit(irq, 1'b1);
    apb(1'b1, reg_addr, 8'ha4);
    apb(1'b0, reg_addr, 8'h00);
    chk(rdata, 32'ha4);
    chk_bit(irq, 1'b0);
    @(posedge clk);
    sub_watch_mode <= 1'b1;
    ext_reset_n_pin <= 1'b0;
    settle(10);
    chk_bit(ext_reset_req, 1'b0);
    @(posedge clk);
    sub_watch_mode <= 1'b0;
    settle(8);
    chk_bit(ext_reset_req, 1'b1);
    summarize();
  end
endmodule
